// *** hdl/spc_params.svh ***
/*
  constants for the sector protection control block: command bytes, table
  codes, sector count and timing figures.
  assumes a 100 MHz system clock; included by bare name.
*/
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

`define SPC_CMD_BYTE1        8'h3D
`define SPC_CMD_BYTE2        8'h2A
`define SPC_CMD_BYTE3        8'h7F
`define SPC_CMD_ENABLE_BYTE  8'hA9
`define SPC_CMD_DISABLE_BYTE 8'h9A
`define SPC_SEQ_BITS         6'd32

`define SPC_MARK_PROTECTED   8'hFF
`define SPC_MARK_OPEN        8'h00

`define SPC_NUM_SECTORS      16

`define SPC_CLK_PERIOD_NS    10
`define SPC_GUARD_ASSERT_DELAY_NS  100
`define SPC_GUARD_RELEASE_DELAY_NS 100
`define SPC_WP_FILTER_NS     50
`define SPC_WP_FILTER_CYCLES (`SPC_WP_FILTER_NS / `SPC_CLK_PERIOD_NS)
`define SPC_GUARD_ASSERT_CYCLES  (`SPC_GUARD_ASSERT_DELAY_NS / `SPC_CLK_PERIOD_NS)
`define SPC_GUARD_RELEASE_CYCLES (`SPC_GUARD_RELEASE_DELAY_NS / `SPC_CLK_PERIOD_NS)

`endif

// *** hdl/spc_pkg.sv ***
/*
  types for the sector protection control block.
  assumes nothing of its surroundings.
*/
package spc_pkg;
  typedef logic [7:0] spc_byte_t;
  typedef enum logic [1:0] {
    SPC_SEQ_NONE,
    SPC_SEQ_ENABLE,
    SPC_SEQ_DISABLE
  } spc_seq_t;
endpackage

// *** hdl/spc_sector_protect.sv ***
/*
  sector protection control: decodes the enable and disable command
  sequences from the serial pins, filters the write-protect pin, keeps the
  protection state and judges program/erase requests.
  assumes serial pins are synchronous to clk_sys (wp_n is resynchronised) and that sck runs
  well below clk_sys/2; the selection table is held outside in nonvolatile
  storage and presented as a flat vector, byte i for sector i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"

module spc_sector_protect
  import spc_pkg::*;
#(
  parameter int NUM_SECTORS   = `SPC_NUM_SECTORS,
  parameter int FILTER_CYCLES = `SPC_WP_FILTER_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     cs_n,
  input  wire logic                     sck,
  input  wire logic                     si,
  input  wire logic                     wp_n,
  input  wire logic [NUM_SECTORS*8-1:0] sel_table,
  input  wire logic                     pe_req,
  input  wire logic [3:0]               pe_sector,
  input  wire logic                     pe_table,
  output logic                          pe_grant_q,
  output logic                          pe_reject_q,
  output logic                          prot_enabled_q,
  output logic                          prot_cmd_q,
  output logic                          table_locked_q
);

  function automatic spc_seq_t decode_seq(input logic [31:0] bits);
    if (bits[31:8] != {`SPC_CMD_BYTE1, `SPC_CMD_BYTE2, `SPC_CMD_BYTE3}) begin
      return SPC_SEQ_NONE;
    end
    if (bits[7:0] == `SPC_CMD_ENABLE_BYTE) begin
      return SPC_SEQ_ENABLE;
    end
    if (bits[7:0] == `SPC_CMD_DISABLE_BYTE) begin
      return SPC_SEQ_DISABLE;
    end
    return SPC_SEQ_NONE;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // serial shift of the command sequence

  logic        sck_q;
  logic        cs_n_q;
  logic [31:0] shift_q;
  logic [5:0]  bit_cnt_q;
  logic        sck_rise;
  logic        cs_release;
  spc_seq_t    seq;

  assign sck_rise   = sck & ~sck_q & ~cs_n;
  assign cs_release = cs_n & ~cs_n_q;
  // only an exact 32-bit frame counts
  assign seq        = (bit_cnt_q == `SPC_SEQ_BITS) ? decode_seq(shift_q) : SPC_SEQ_NONE;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sck_q  <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q  <= sck;
      cs_n_q <= cs_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shift_q   <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
    end else if (cs_n) begin
      bit_cnt_q <= 6'h00;
    end else if (sck_rise) begin
      shift_q   <= {shift_q[30:0], si};
      // saturate past 32 so over-long frames never match
      if (bit_cnt_q != 6'h3F) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write-protect pin synchroniser and glitch filter

  logic       wp_s1_q;
  logic       wp_s2_q;
  logic       wp_filt_q;
  logic [7:0] filt_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      wp_s1_q <= wp_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wp_filt_q  <= 1'b1;
      filt_cnt_q <= 8'h00;
    end else if (wp_s2_q == wp_filt_q) begin
      filt_cnt_q <= 8'h00;
    end else if (filt_cnt_q == 8'(FILTER_CYCLES - 1)) begin
      wp_filt_q  <= wp_s2_q;
      filt_cnt_q <= 8'h00;
    end else begin
      filt_cnt_q <= filt_cnt_q + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // protection state

  logic prot_eff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prot_cmd_q <= 1'b0;
    end else if (cs_release && seq == SPC_SEQ_ENABLE) begin
      prot_cmd_q <= 1'b1;
    end else if (cs_release && seq == SPC_SEQ_DISABLE && wp_filt_q) begin
      prot_cmd_q <= 1'b0;
    end
  end

  // pin only adds guarding; the command flag itself is never altered by it
  assign prot_eff = prot_cmd_q | ~wp_filt_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prot_enabled_q <= 1'b0;
      table_locked_q <= 1'b0;
    end else begin
      prot_enabled_q <= prot_eff;
      table_locked_q <= ~wp_filt_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program/erase request gating

  logic [NUM_SECTORS-1:0] marked;

  for (genvar i = 0; i < NUM_SECTORS; i++) begin : g_mark
    assign marked[i] = (sel_table[i*8 +: 8] == `SPC_MARK_PROTECTED);
  end

  logic refuse;
  assign refuse = pe_table ? ~wp_filt_q
                           : (prot_eff & marked[pe_sector]);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pe_grant_q  <= 1'b0;
      pe_reject_q <= 1'b0;
    end else begin
      pe_grant_q  <= pe_req & ~refuse;
      pe_reject_q <= pe_req & refuse;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  cmd_enable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_release && bit_cnt_q == `SPC_SEQ_BITS
    && shift_q == {`SPC_CMD_BYTE1, `SPC_CMD_BYTE2, `SPC_CMD_BYTE3, `SPC_CMD_ENABLE_BYTE}
    |=> prot_cmd_q ##1 prot_enabled_q)
    else $error("enable sequence did not set protection");

  cmd_disable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_release && bit_cnt_q == 6'd32 && shift_q == 32'h3D2A_7F9A && wp_filt_q |=> !prot_cmd_q ##1 !prot_enabled_q)
    else $error("disable sequence did not clear protection");

  reset_clear_a: assert property (@(posedge clk_sys)
    !reset_n |=> !prot_cmd_q && !prot_enabled_q && !pe_grant_q)
    else $error("reset left protection state set");

  disable_ignored_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_release && !wp_filt_q && seq == SPC_SEQ_DISABLE |=> $stable(prot_cmd_q) && prot_enabled_q)
    else $error("disable acted while pin low");

  short_frame_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_release && bit_cnt_q != 6'd32 |=> $stable(prot_cmd_q))
    else $error("short frame changed protection");

  wp_assert_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!wp_n)[*8] |-> ##[1:2] prot_enabled_q)
    else $error("low pin did not assert protection in time");

  wp_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wp_n && !prot_cmd_q)[*8] ##1 !prot_cmd_q |-> ##[0:1] !prot_enabled_q)
    else $error("protection stayed on after pin release");

  glitch_filter_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(wp_filt_q) |-> $past(filt_cnt_q) == 8'(FILTER_CYCLES - 1) && wp_filt_q == $past(wp_s2_q))
    else $error("filtered pin moved without a stable run");

  sector_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pe_req && !pe_table && prot_eff && marked[pe_sector] |=> pe_reject_q && !pe_grant_q)
    else $error("write to guarded sector granted");

  sector_open_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pe_req && !pe_table && !marked[pe_sector] |=> pe_grant_q && !pe_reject_q)
    else $error("write to unmarked sector refused");

  table_lock_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pe_req && pe_table && !wp_filt_q |=> pe_reject_q ##0 table_locked_q)
    else $error("table write granted while pin low");

  status_track_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 prot_enabled_q == $past(prot_cmd_q | ~wp_filt_q))
    else $error("status does not follow protection state");

  enable_seen_c:  cover property (@(posedge clk_sys) disable iff (!reset_n) cs_release && seq == SPC_SEQ_ENABLE);
  wp_hold_c:      cover property (@(posedge clk_sys) disable iff (!reset_n) prot_cmd_q && !wp_filt_q ##[1:50] wp_filt_q);
  reject_c:       cover property (@(posedge clk_sys) disable iff (!reset_n) pe_reject_q);
  ignored_dis_c:  cover property (@(posedge clk_sys) disable iff (!reset_n)
                    cs_release && seq == SPC_SEQ_DISABLE && !wp_filt_q);

endmodule // spc_sector_protect

`default_nettype wire

// *** dv/spc_host_model.sv ***
/*
  serial host model: sends four-byte command frames on the serial pins.
  assumes clk_sys from the bench; all pins change at its falling edge.
*/
`timescale 1ns/10ps
`default_nettype none

module spc_host_model (
  input  wire logic clk_sys,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // a deselected data line toggles so no stale bit looks valid
  always @(negedge clk_sys) begin
    if (cs_n) begin
      si <= ~si;
    end
  end

  // msb first; n below 32 cuts the frame short, above 32 adds zero bits
  task automatic send(input logic [31:0] w, input int n);
    @(negedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      si <= (i < 32) ? w[31-i] : 1'b0;
      repeat (2) @(negedge clk_sys);
      sck <= 1'b1;
      repeat (2) @(negedge clk_sys);
      sck <= 1'b0;
    end
    @(negedge clk_sys);
    cs_n <= 1'b1;
  endtask
endmodule // spc_host_model

`default_nettype wire

// *** dv/tb.sv ***
/*
  self-checking bench for the sector protection control block.
  assumes the host model in the same folder; random requests with fixed seed.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"

module tb;
  import spc_pkg::*;
  localparam int NS = `SPC_NUM_SECTORS;
  localparam int DLY = `SPC_GUARD_ASSERT_CYCLES;
  localparam logic [23:0] HEAD = {`SPC_CMD_BYTE1, `SPC_CMD_BYTE2, `SPC_CMD_BYTE3};
  localparam logic [31:0] EN = {HEAD, `SPC_CMD_ENABLE_BYTE};
  localparam logic [31:0] DIS = {HEAD, `SPC_CMD_DISABLE_BYTE};
  logic            clk_sys = 1'b0;
  logic            reset_n = 1'b0;
  logic            wp_n = 1'b1;
  logic            pe_req = 1'b0;
  logic            pe_table = 1'b0;
  logic [3:0]      pe_sector = 4'h0;
  logic [NS*8-1:0] sel_table = '0;
  wire logic       cs_n, sck, si, grant, reject, prot, cmd, locked;
  int              fail_count = 0;
  int              checks = 0;
  int              seed = 15259;

  always #5 clk_sys = ~clk_sys;

  spc_host_model u_host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si));

  spc_sector_protect #(.NUM_SECTORS(NS), .FILTER_CYCLES(2)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .sel_table(sel_table), .pe_req(pe_req), .pe_sector(pe_sector), .pe_table(pe_table),
    .pe_grant_q(grant), .pe_reject_q(reject), .prot_enabled_q(prot), .prot_cmd_q(cmd),
    .table_locked_q(locked));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic state(input string name, input logic p, input logic c, input logic l);
    cmp1("prot_enabled_q", p, prot);
    cmp1("prot_cmd_q", c, cmd);
    cmp1("table_locked_q", l, locked);
    $display("test %s done", name);
  endtask

  function automatic logic exp_grant(input logic tbl, input logic [3:0] s, input logic p, input logic l);
    if (tbl)
      return !l;
    return !(p && sel_table[{s, 3'b000} +: 8] == `SPC_MARK_PROTECTED);
  endfunction

  // back-to-back requests; each answer is checked while the next is offered
  task automatic burst(input int n, input logic p, input logic l);
    logic e;
    e = 1'b0;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_sys);
      if (i == 0)
        for (int k = 0; k < NS; k++)
          sel_table[k*8 +: 8] = $random(seed) & 1 ? `SPC_MARK_PROTECTED : `SPC_MARK_OPEN;
      else begin
        cmp1("pe_grant_q", e, grant);
        cmp1("pe_reject_q", !e, reject);
      end
      pe_req = (i < n);
      pe_table = ($random(seed) & 7) == 0;
      pe_sector = 4'($random(seed));
      e = exp_grant(pe_table, pe_sector, p, l);
    end
    $display("test burst done");
  endtask

  task automatic frame(input logic [31:0] w, input int n);
    u_host.send(w, n);
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic set_wp(input logic v, input int hold);
    wp_n = v;
    repeat (hold) @(negedge clk_sys);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500_000;
    fail_count++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    state("reset", 0, 0, 0);
    burst(20, 0, 0);
    frame(EN, 31);
    state("short", 0, 0, 0);
    frame(EN, 33);
    state("long", 0, 0, 0);
    frame({HEAD, 8'h5C}, 32);
    state("foreign", 0, 0, 0);
    frame(EN, 32);
    state("enable", 1, 1, 0);
    burst(40, 1, 0);
    frame(DIS, 32);
    state("disable", 0, 0, 0);
    set_wp(0, 1);
    set_wp(1, DLY);
    state("low glitch", 0, 0, 0);
    set_wp(0, DLY);
    state("pin low", 1, 0, 1);
    burst(40, 1, 1);
    frame(DIS, 32);
    state("disable low", 1, 0, 1);
    set_wp(1, 1);
    set_wp(0, DLY);
    state("high glitch", 1, 0, 1);
    set_wp(1, DLY);
    state("pin high", 0, 0, 0);
    set_wp(0, DLY);
    frame(EN, 32);
    set_wp(1, DLY);
    state("kept", 1, 1, 0);
    frame(DIS, 32);
    state("dropped", 0, 0, 0);
    frame(EN, 32);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    state("re-reset", 0, 0, 0);
    end_sim();
  end
endmodule // tb

`default_nettype wire
